// file: common/cbt_pkg.sv
`default_nettype none
package cbt_pkg;
    // Register byte addresses on the APB.
    localparam logic [7:0] ADDR_CTRL_ONE   = 8'h00;
    localparam logic [7:0] ADDR_CTRL_TWO   = 8'h04;
    localparam logic [7:0] ADDR_CTRL_THREE = 8'h08;
    localparam logic [7:0] ADDR_MODE       = 8'h0c;
    localparam logic [7:0] ADDR_STATUS     = 8'h10;

    // Field positions.
    localparam int SJW_LSB      = 6;
    localparam int PH2_SEL_BIT  = 7;
    localparam int TRIPLE_BIT   = 6;
    localparam int PH1_LSB      = 3;
    localparam int WAKE_FLT_BIT = 6;

    // Reset values and the writable bits of the third register.
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] CTRL3_MASK  = 8'h47;
    localparam logic       MODE_RESET  = 1'b1;

    // Processing time in quanta, and the wake-up filter time.
    localparam logic [3:0] IPT_QUANTA     = 4'h2;
    localparam int         CLK_PERIOD_NS  = 25;
    localparam int         WAKE_FILTER_NS = 200;
    localparam logic [3:0] WAKE_FILTER_CYC =
        4'((WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [3:0] {
        SEG_SYNC = 4'b0001,
        SEG_PROP = 4'b0010,
        SEG_PH1  = 4'b0100,
        SEG_PH2  = 4'b1000
    } cbt_seg_type;

    typedef struct packed {
        logic [7:0]  one;
        logic [7:0]  two;
        logic [7:0]  three;
        logic        cfg;
        logic [2:0]  rxs;
        logic        rxSt;
        logic        rxPrev;
        logic        edgeSeen;
        logic [6:0]  preCnt;
        cbt_seg_type seg;
        logic [3:0]  segCnt;
        logic [4:0]  inBit;
        logic [2:0]  ext;
        logic [1:0]  hist;
        logic        bitVal;
        logic        sampPt;
        logic        bitSt;
        logic [3:0]  wakeCnt;
        logic        wakeEv;
        logic [31:0] rdata;
        logic        err;
    } cbt_state_type;

    localparam cbt_state_type STATE_RESET = '{one: CTRL_RESET, two: CTRL_RESET,
        three: CTRL_RESET, cfg: MODE_RESET, seg: SEG_SYNC, rxs: 3'h7, rxSt: 1'b1,
        rxPrev: 1'b1, bitVal: 1'b1, default: '0};
endpackage : cbt_pkg
`default_nettype wire

// file: logic/cbt_bit_timing.sv
// Functional notes
// - Jump-width field 00..11 gives a resync jump of one to four quanta.
// - Quantum lasts twice (prescaler field plus one) clock periods.
// - Timing registers one and two are writable only in configuration mode.
// - Select set: phase 2 from field; clear: max of phase 1 and INFORMATION_PROCESSING_TIME.
// - Triple-sample bit set takes majority of three samples, else one sample.
// - Phase segment 1 lasts field plus one quanta.
// - Propagation segment lasts field plus one quanta.
// - Phase segment 2 field gives field plus one quanta.
// - Phase segment 2 field is ignored while the select bit is clear.
// - Wake-up filter bit chooses filtered or raw bus line for wake-up.
// - Third register bits 7 and 5..3 always read as zero.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module cbt_bit_timing
    import cbt_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        canRx,
    output logic             sampledBit,
    output logic             samplePoint,
    output logic             bitStart,
    output logic             wakeActivity,
    output logic             configMode
);
    cbt_state_type q;
    cbt_state_type d;
    logic [6:0] tqLast;
    logic       tick;
    logic       fall;
    logic       edgeNow;
    logic [2:0] sjwQ;
    logic [2:0] extNew;
    logic [3:0] propLen;
    logic [3:0] ph1Base;
    logic [3:0] ph1Len;
    logic [3:0] ph2Len;
    logic       majority;
    logic       setup;
    logic       access;
    logic       mapped;
    logic       timingReg;
    logic       errNow;
    logic [31:0] readVal;

    // All state advances together; reset forces the constant image.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    // Next-state logic: APB slave, bus line input, quantum and segment engine.
    always_comb begin
        d = q;
        setup = psel & ~penable;
        access = psel & penable;
        tqLast = {q.one[5:0], 1'b1};
        tick = (q.preCnt == tqLast);
        fall = q.rxPrev & ~q.rxSt;
        edgeNow = q.edgeSeen | fall;
        sjwQ = {1'b0, q.one[SJW_LSB+1:SJW_LSB]} + 3'h1;
        propLen = {1'b0, q.two[2:0]} + 4'h1;
        ph1Base = {1'b0, q.two[PH1_LSB+2:PH1_LSB]} + 4'h1;
        // Only one phase 1 extension per bit, limited by the jump width.
        extNew = q.ext;
        if (edgeNow && (q.ext == 3'h0) && (q.seg == SEG_PROP || q.seg == SEG_PH1)) begin
            extNew = (q.inBit < {2'b00, sjwQ}) ? q.inBit[2:0] : sjwQ;
        end
        ph1Len = ph1Base + {1'b0, extNew};
        if (q.two[PH2_SEL_BIT]) begin
            ph2Len = {1'b0, q.three[2:0]} + 4'h1;
        end else begin
            ph2Len = (ph1Base > IPT_QUANTA) ? ph1Base : IPT_QUANTA;
        end
        majority = (q.hist[1] & q.hist[0]) | (q.hist[1] & q.rxSt) | (q.hist[0] & q.rxSt);

        // Address decode and read mux.
        mapped = 1'b1;
        timingReg = 1'b0;
        case (paddr)
            ADDR_CTRL_ONE: begin
                readVal = {24'h0, q.one};
                timingReg = 1'b1;
            end
            ADDR_CTRL_TWO: begin
                readVal = {24'h0, q.two};
                timingReg = 1'b1;
            end
            ADDR_CTRL_THREE: readVal = {24'h0, q.three & CTRL3_MASK};
            ADDR_MODE:       readVal = {31'h0, q.cfg};
            ADDR_STATUS:     readVal = {26'h0, q.rxSt, q.bitVal, q.seg};
            default: begin
                readVal = 32'h0;
                mapped = 1'b0;
            end
        endcase

        // Refusal is judged in the access phase itself. A mode write that ends at the
        // very edge on which the next setup is taken must still lock or free that write.
        errNow = ~mapped | (pwrite & timingReg & ~q.cfg);

        // Read data is prepared in the setup cycle so the access phase needs no wait.
        if (setup) begin
            d.rdata = pwrite ? 32'h0 : readVal;
        end
        // Flags, for one cycle only, that the access phase just ended was refused.
        d.err = access & errNow;
        if (access && pwrite && !errNow) begin
            case (paddr)
                ADDR_CTRL_ONE:   d.one = pwdata[7:0];
                ADDR_CTRL_TWO:   d.two = pwdata[7:0];
                ADDR_CTRL_THREE: d.three = pwdata[7:0] & CTRL3_MASK;
                ADDR_MODE:       d.cfg = pwdata[0];
                default:         d.cfg = q.cfg;
            endcase
        end

        // Three-stage synchroniser; a change counts once stages two and three agree.
        d.rxs = {q.rxs[1:0], canRx};
        if (q.rxs[1] == q.rxs[2]) begin
            d.rxSt = q.rxs[2];
        end
        d.rxPrev = q.rxSt;

        // Wake-up detection, with the filter rejecting short dominant glitches.
        if (q.rxSt) begin
            d.wakeCnt = 4'h0;
        end else if (q.wakeCnt != WAKE_FILTER_CYC) begin
            d.wakeCnt = q.wakeCnt + 4'h1;
        end
        if (q.three[WAKE_FLT_BIT]) begin
            d.wakeEv = ~q.rxSt & (q.wakeCnt == WAKE_FILTER_CYC - 4'h1);
        end else begin
            d.wakeEv = fall;
        end

        // Bit timing engine; held idle in configuration mode.
        d.sampPt = 1'b0;
        d.bitSt = 1'b0;
        if (q.cfg) begin
            d.preCnt = 7'h0;
            d.seg = SEG_SYNC;
            d.segCnt = 4'h0;
            d.inBit = 5'h0;
            d.ext = 3'h0;
            d.edgeSeen = 1'b0;
        end else if (!tick) begin
            d.preCnt = q.preCnt + 7'h1;
            d.edgeSeen = edgeNow; // An edge waits for the next quantum boundary.
        end else begin
            d.preCnt = 7'h0;
            d.edgeSeen = 1'b0;
            d.hist = {q.hist[0], q.rxSt};
            d.inBit = q.inBit + 5'h1;
            d.segCnt = q.segCnt + 4'h1;
            d.ext = extNew;
            case (q.seg)
                SEG_SYNC: begin
                    d.seg = SEG_PROP;
                    d.segCnt = 4'h0;
                    d.inBit = 5'h1;
                    d.ext = 3'h0;
                end
                SEG_PROP: begin
                    if (q.segCnt == propLen - 4'h1) begin
                        d.seg = SEG_PH1;
                        d.segCnt = 4'h0;
                    end
                end
                SEG_PH1: begin
                    if (q.segCnt == ph1Len - 4'h1) begin
                        d.seg = SEG_PH2;
                        d.segCnt = 4'h0;
                        d.sampPt = 1'b1;
                        d.bitVal = q.two[TRIPLE_BIT] ? majority : q.rxSt;
                    end
                end
                SEG_PH2: begin
                    // An early edge cuts phase 2 short by at most the jump width.
                    if ((q.segCnt == ph2Len - 4'h1) ||
                        (edgeNow && (4'(ph2Len - 4'h1 - q.segCnt) <= {1'b0, sjwQ}))) begin
                        d.seg = SEG_SYNC;
                        d.segCnt = 4'h0;
                        d.bitSt = 1'b1;
                    end
                end
                default: begin
                    d.seg = SEG_SYNC;
                    d.segCnt = 4'h0;
                end
            endcase
        end
    end

    // Outputs; the slave never inserts wait states.
    assign pready       = 1'b1;
    assign pslverr      = errNow & psel & penable;
    assign prdata       = q.rdata;
    assign sampledBit   = q.bitVal;
    assign samplePoint  = q.sampPt;
    assign bitStart     = q.bitSt;
    assign wakeActivity = q.wakeEv;
    assign configMode   = q.cfg;

    default clocking cbClk @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_jump_width_cap: assert property (
        q.seg == SEG_PH1 |-> q.ext <= ({1'b0, q.one[7:6]} + 3'h1))
        else $error("Phase 1 extension exceeds jump width.");

    a_quantum_min_len: assert property (
        tick && !q.cfg && q.one[5:0] == 6'h00 && !d.cfg |=> !tick ##1 tick)
        else $error("Quantum of two periods has wrong length.");

    a_quantum_two_len: assert property (
        tick && !q.cfg && q.one[5:0] == 6'h01 && $stable(q.one) |=> !tick[*3] ##1 tick)
        else $error("Quantum of four periods has wrong length.");

    a_cfg_write_refused: assert property (
        psel && penable && pwrite && paddr == ADDR_CTRL_ONE && !q.cfg
        |-> pslverr ##1 $stable(q.one))
        else $error("Timing write accepted outside configuration mode.");

    a_ph2_free_len: assert property (
        q.seg == SEG_PH2 && tick && !edgeNow && !q.cfg && q.two[7]
        |-> (d.seg == SEG_SYNC) == (q.segCnt == {1'b0, q.three[2:0]}))
        else $error("Programmed phase 2 length not kept.");

    a_ph2_auto_len: assert property (
        q.seg == SEG_PH2 && tick && !edgeNow && !q.cfg && !q.two[7]
        |-> (d.seg == SEG_SYNC) == (q.segCnt == ((q.two[5:3] >= 3'h1) ?
            {1'b0, q.two[5:3]} : (IPT_QUANTA - 4'h1))))
        else $error("Automatic phase 2 length wrong.");

    a_single_sample: assert property (
        samplePoint && !q.two[6] |-> sampledBit == $past(q.rxSt))
        else $error("Single sample does not match bus line.");

    a_triple_sample: assert property (
        samplePoint && q.two[6] && $past(q.hist) == 2'b00 |-> !sampledBit)
        else $error("Majority of three samples wrong.");

    a_ph1_len: assert property (
        q.seg == SEG_PH1 && tick && !edgeNow && q.ext == 3'h0 && !q.cfg
        |-> (d.seg == SEG_PH2) == (q.segCnt == {1'b0, q.two[5:3]}))
        else $error("Phase 1 length wrong.");

    a_prop_len: assert property (
        q.seg == SEG_PROP && tick && !q.cfg
        |-> (d.seg == SEG_PH1) == (q.segCnt == {1'b0, q.two[2:0]}))
        else $error("Propagation length wrong.");

    a_ctrl3_reads_zero: assert property (
        psel && !penable && !pwrite && paddr == ADDR_CTRL_THREE
        |=> prdata[7] == 1'b0 && prdata[5:3] == 3'h0)
        else $error("Unimplemented bits read as one.");

    a_wake_filtered: assert property (
        wakeActivity && q.three[6] |-> $past(q.rxSt, 1) == 1'b0 && $past(q.rxSt, 8) == 1'b0)
        else $error("Filtered wake-up on a short pulse.");

    a_wake_raw: assert property (
        wakeActivity && !q.three[6] |-> $past(q.rxPrev & ~q.rxSt))
        else $error("Raw wake-up without a falling edge.");

    a_seg_order: assert property (
        q.seg == SEG_SYNC && tick && !q.cfg && !d.cfg |=> q.seg == SEG_PROP)
        else $error("Sync quantum not followed by propagation.");

    a_sample_at_ph1: assert property (
        samplePoint |-> q.seg == SEG_PH2 && q.segCnt == 4'h0 && $past(q.seg) == SEG_PH1)
        else $error("Sample point not at end of phase 1.");

    // The checks below guard the register bus as a whole. They matter most for
    // back-to-back transfers, which the access-phase refusal above was built for.
    a_ctrl_two_refused: assert property (
        psel && penable && pwrite && paddr == ADDR_CTRL_TWO && !q.cfg
        |-> pslverr ##1 $stable(q.two))
        else $error("Second timing write accepted outside configuration mode.");

    a_cfg_write_lands: assert property (
        psel && penable && pwrite && paddr == ADDR_CTRL_ONE && q.cfg
        |=> q.one == $past(pwdata[7:0]))
        else $error("Timing write lost in configuration mode.");

    a_ctrl3_write_mask: assert property (
        psel && penable && pwrite && paddr == ADDR_CTRL_THREE
        |=> (q.three & ~CTRL3_MASK) == 8'h00)
        else $error("Unimplemented bits stored.");

    a_err_remembered: assert property (
        pslverr |=> q.err)
        else $error("Refused transfer not remembered.");

    // Of the engine checks below, the first holds in configuration mode and the prescaler bound only while the timing registers are frozen.
    a_engine_idle_cfg: assert property (
        q.cfg |=> q.seg == SEG_SYNC && q.preCnt == 7'h0)
        else $error("Timing engine runs in configuration mode.");

    a_prescaler_bound: assert property (
        !q.cfg |-> q.preCnt <= tqLast)
        else $error("Quantum counter passed its end.");

    a_prop_cnt_cap: assert property (
        q.seg == SEG_PROP |-> q.segCnt < propLen)
        else $error("Propagation counter passed its end.");

    a_sample_single: assert property (
        samplePoint |=> !samplePoint)
        else $error("Sample point pulse longer than one cycle.");

    // Cover points for the main scenarios; a refused write and a filtered
    // wake-up are the ones most easily missed by a short run.
    c_triple_sample: cover property (samplePoint && q.two[6]);
    c_wake_filtered: cover property (wakeActivity && q.three[6]);
    c_ph2_shortened: cover property (q.seg == SEG_PH2 && edgeNow && tick && d.seg == SEG_SYNC);
    c_ph1_extended: cover property (q.seg == SEG_PH1 && q.ext != 3'h0);
    c_write_refused: cover property (pslverr && pwrite);
endmodule : cbt_bit_timing
`default_nettype wire

// file: test/cbt_bus_node.sv
`timescale 1ns/1ps
`default_nettype none
// Stands in for another node on the bus: it pulls the line dominant for a set stretch.
module cbt_bus_node (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic [15:0] domLen,
    output logic             canRx
);
    logic [15:0] left_q;

    // Counts the dominant stretch down; a released bus is pulled back to recessive (one).
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            left_q <= 16'h0000;
        end else if (go) begin
            left_q <= domLen;
        end else if (left_q != 16'h0000) begin
            left_q <= left_q - 16'h0001;
        end
    end

    assign canRx = (left_q == 16'h0000);
endmodule : cbt_bus_node
`default_nettype wire

// file: test/can_bit_timing_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module can_bit_timing_config_tb
    import cbt_pkg::*;
;
    logic        mclk    = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h00000000;
    logic        busGo   = 1'b0;
    logic [15:0] busLen  = 16'h0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        canRx;
    logic        sampledBit;
    logic        samplePoint;
    logic        bitStart;
    logic        wakeActivity;
    logic        configMode;
    int          n_errors = 0;
    int          checks   = 0;

    cbt_bit_timing u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .canRx(canRx), .sampledBit(sampledBit),
        .samplePoint(samplePoint), .bitStart(bitStart), .wakeActivity(wakeActivity),
        .configMode(configMode));

    cbt_bus_node u_node (.mclk(mclk), .rst(rst), .go(busGo), .domLen(busLen),
        .canRx(canRx));

    // The clock toggles every half period of 25 ns.
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, {31'h0, ee}, "write error flag");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 8'h00, r, e);
        chk(r, x, "read data");
        chk({31'h0, e}, {31'h0, ee}, "read error flag");
    endtask : rd

    task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
        wr(ADDR_MODE, 8'h01, 1'b0);
        wr(ADDR_CTRL_ONE, c1, 1'b0);
        wr(ADDR_CTRL_TWO, c2, 1'b0);
        wr(ADDR_CTRL_THREE, c3, 1'b0);
        wr(ADDR_MODE, 8'h00, 1'b0);
    endtask : cfg

    // Registers come out of reset cleared, in configuration mode.
    task automatic t_reset();
        rd(ADDR_CTRL_ONE, 32'h00, 1'b0);
        rd(ADDR_CTRL_TWO, 32'h00, 1'b0);
        rd(ADDR_CTRL_THREE, 32'h00, 1'b0);
        rd(ADDR_MODE, 32'h01, 1'b0);
        rd(ADDR_STATUS, 32'h31, 1'b0);
        chk({31'h0, configMode}, 32'h1, "config mode after reset");
    endtask : t_reset

    // Full writes, unimplemented bits and an unmapped address.
    task automatic t_regs();
        wr(ADDR_CTRL_ONE, 8'hff, 1'b0);
        rd(ADDR_CTRL_ONE, 32'hff, 1'b0);
        wr(ADDR_CTRL_TWO, 8'hff, 1'b0);
        rd(ADDR_CTRL_TWO, 32'hff, 1'b0);
        wr(ADDR_CTRL_THREE, 8'hff, 1'b0);
        rd(ADDR_CTRL_THREE, 32'h47, 1'b0);
        wr(8'h14, 8'h01, 1'b1);
        rd(8'h14, 32'h00, 1'b1);
    endtask : t_regs

    // Outside configuration mode the first two registers refuse writes.
    task automatic t_lock();
        wr(ADDR_MODE, 8'h00, 1'b0);
        wr(ADDR_CTRL_ONE, 8'h12, 1'b1);
        rd(ADDR_CTRL_ONE, 32'hff, 1'b0);
        wr(ADDR_CTRL_TWO, 8'h34, 1'b1);
        rd(ADDR_CTRL_TWO, 32'hff, 1'b0);
        wr(ADDR_CTRL_THREE, 8'h00, 1'b0);
        rd(ADDR_CTRL_THREE, 32'h00, 1'b0);
    endtask : t_lock

    // Measures sample point and bit length on an idle bus against the segment sums.
    task automatic t_timing(input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3);
        int q;
        int p1;
        int p2;
        int sp;
        int n;
        q  = 2 * (int'(c1[5:0]) + 1);
        p1 = int'(c2[5:3]) + 1;
        p2 = c2[7] ? int'(c3[2:0]) + 1 : ((p1 > 2) ? p1 : 2);
        sp = (2 + int'(c2[2:0]) + p1) * q;
        cfg(c1, c2, c3);
        n = 0;
        while (bitStart !== 1'b1 && n < 9000) begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (samplePoint !== 1'b1 && n < 9000);
        chk(32'(n), 32'(sp), "sample point position");
        do begin
            @(negedge mclk);
            n++;
        end while (bitStart !== 1'b1 && n < 9000);
        chk(32'(n), 32'(sp + p2 * q), "bit length");
    endtask : t_timing

    // A node holds the bus dominant over several bits, then releases it.
    task automatic t_sample(input logic triple_sample_select);
        cfg(8'h00, {1'b1, triple_sample_select, 6'h00}, 8'h00);
        @(posedge mclk);
        busLen <= 16'd48;
        busGo  <= 1'b1;
        @(posedge mclk);
        busGo  <= 1'b0;
        repeat (44) @(negedge mclk);
        chk({31'h0, sampledBit}, 32'h0, "dominant not sampled");
        repeat (48) @(negedge mclk);
        chk({31'h0, sampledBit}, 32'h1, "recessive not sampled");
    endtask : t_sample

    // Counts wake pulses for one dominant stretch with or without the line filter.
    task automatic t_wake(input logic filt, input int len, input int exp);
        int cnt;
        cnt = 0;
        wr(ADDR_MODE, 8'h01, 1'b0);
        wr(ADDR_CTRL_THREE, {1'b0, filt, 6'h00}, 1'b0);
        @(posedge mclk);
        busLen <= 16'(len);
        busGo  <= 1'b1;
        @(posedge mclk);
        busGo  <= 1'b0;
        repeat (len + 30) begin
            @(negedge mclk);
            if (wakeActivity === 1'b1) cnt++;
        end
        chk(32'(cnt), 32'(exp), "wake pulse count");
    endtask : t_wake

    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    // The slowest setting runs 3200 cycles a bit, so this limit leaves ample room.
    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_lock();
        t_timing(8'h00, 8'h80, 8'h00);
        t_timing(8'hc1, 8'h80, 8'h00);
        t_timing(8'h00, 8'h00, 8'h07);
        t_timing(8'h00, 8'h18, 8'h00);
        t_timing(8'h00, 8'h9a, 8'h07);
        t_timing(8'h3f, 8'h3f, 8'h00);
        t_sample(1'b0);
        t_sample(1'b1);
        t_wake(1'b0, 3, 1);
        t_wake(1'b1, 4, 0);
        t_wake(1'b1, 16, 1);
        wrap_up();
    end
endmodule : can_bit_timing_config_tb
`default_nettype wire
